// ==== pds_pkg.sv ====
// Package of constants for the power-domain and reset-default block.
// Assumes a 100 MHz system clock and a plain strobe register port.
package pds_pkg;
  // ********************
  // Register map
  // ********************
  localparam logic [7:0] SLOW_CLOCK_PRESENCE_ADDR = 8'hf0;
  localparam logic [7:0] PIN_CONTROL_ADDR = 8'hf1;
  localparam logic [7:0] POWER_STATUS_ADDR = 8'hf2;
  localparam int SLOW_CLOCK_ABSENT_BIT = 0;
  localparam logic SLOW_CLOCK_PRESENCE_RESET = 1'h0;
  // Pin control fields.
  localparam int ACTIVATE_BIT = 0;
  localparam int KBD_FUNC_BIT = 1;
  localparam int GATE_FUNC_BIT = 2;
  localparam int IR_TIMEOUT_EN_BIT = 3;
  localparam int FAN_INVERT_BIT = 4;
  localparam logic [7:0] PIN_CONTROL_RESET = 8'h00;
  // ********************
  // Configuration base
  // ********************
  localparam logic [11:0] CONFIG_BASE_LOW = 12'h02e;
  localparam logic [11:0] CONFIG_BASE_HIGH = 12'h04e;
  // ********************
  // Clocks
  // ********************
  localparam int SYS_CLK_HZ = 100_000_000;
  localparam int REF_CLK_HZ = 14_318_180;
  localparam int SLOW_CLK_HZ = 32_768;
  // Half period of the derived slow clock in reference ticks.
  localparam int DERIVED_HALF_TICKS = REF_CLK_HZ / (2 * SLOW_CLK_HZ);
  localparam int DIV_WIDTH = 9;
  // Power sequencing states.
  typedef enum logic [2:0] {
    PDS_OFF = 3'b001,
    PDS_HOLD = 3'b010,
    PDS_RUN = 3'b100
  } pds_state_t;
endpackage

// ==== pds_sync.sv ====
// Two flip-flop synchroniser for one level.
// Assumes the destination reset is asynchronous and active low.
`timescale 1ns/1ps
`default_nettype none
module pds_sync
(
  // Clock and reset.
  input wire logic i_clk,
  input wire logic i_rst_n,
  // Data.
  input wire logic i_d,
  output logic o_q
);
  logic first;
  // The first stage feeds only the second stage.
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      first <= 1'b0;
      o_q <= 1'b0;
    end
    else
    begin
      first <= i_d;
      o_q <= first;
    end
  end
endmodule
`default_nettype wire

// ==== pds_slow_clock.sv ====
// Derived slow-clock tick generator and source selector.
// Assumes the reference clock is already sampled into the system domain.
`timescale 1ns/1ps
`default_nettype none
module pds_slow_clock
#(
  parameter int HALF_TICKS = pds_pkg::DERIVED_HALF_TICKS
)
(
  // Clock and reset.
  input wire logic i_clk,
  input wire logic i_rst_n,
  // Sources.
  input wire logic i_ref_level,
  input wire logic i_ext_level,
  input wire logic i_use_derived,
  // Selected slow clock level.
  output logic o_slow
);
  logic ref_prev;
  logic [pds_pkg::DIV_WIDTH-1:0] count;
  logic derived;
  logic next_ref_prev;
  logic [pds_pkg::DIV_WIDTH-1:0] next_count;
  logic next_derived;
  logic next_slow;
  // Divide reference edges down to a nominal 32 kHz square wave.
  always_comb
  begin
    next_ref_prev = i_ref_level;
    next_count = count;
    next_derived = derived;
    if (i_ref_level && !ref_prev)
    begin
      if (count == pds_pkg::DIV_WIDTH'(HALF_TICKS - 1))
      begin
        next_count = '0;
        next_derived = !derived;
      end
      else
      begin
        next_count = count + pds_pkg::DIV_WIDTH'(1);
      end
    end
    next_slow = i_use_derived ? derived : i_ext_level;
  end
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      ref_prev <= 1'b0;
      count <= '0;
      derived <= 1'b0;
      o_slow <= 1'b0;
    end
    else
    begin
      ref_prev <= next_ref_prev;
      count <= next_count;
      derived <= next_derived;
      o_slow <= next_slow;
    end
  end
endmodule
`default_nettype wire

// ==== pds_power_domain.sv ====
// Power-domain gating and reset defaults for the I/O controller pins.
// Assumes the standby rail reset is i_arst_n and main supply good is a pin.
//
// Decided for this implementation: strobed register access.
`timescale 1ns/1ps
`default_nettype none
module pds_power_domain
(
  // Clock and standby reset.
  input wire logic i_sys_clk,
  input wire logic i_arst_n,
  // Supply and platform pins.
  input wire logic i_main_supply_ok,
  input wire logic i_platform_reset_in_n,
  input wire logic i_hard_reset,
  input wire logic i_config_base_strap,
  // Clock source pins.
  input wire logic i_slow_clock_in,
  input wire logic i_ref_clock_in,
  // Host register port.
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  // Function inputs.
  input wire logic i_uart2_txd,
  input wire logic [1:0] i_fan_pwm,
  input wire logic [1:0] i_fan_gpio,
  input wire logic [1:0] i_led,
  input wire logic i_kbd_reset_func,
  input wire logic i_gate_a20_func,
  input wire logic i_wake_event,
  // Pins driven.
  output logic o_infrared_transmit_pin_a,
  output logic o_infrared_transmit_pin_b,
  output logic o_fan_drive_out_1,
  output logic o_fan_drive_out_2,
  output logic o_indicator_out_1,
  output logic o_indicator_out_2,
  output logic o_keyboard_reset_out,
  output logic o_keyboard_reset_oe,
  output logic o_gate_a20_out,
  output logic o_gate_a20_oe,
  output logic o_wake_event_out_n,
  // Status.
  output logic [11:0] o_config_base,
  output logic o_ir_timeout_en,
  output logic o_main_domain_rst_n,
  output logic o_slow_clock
);
  // ********************
  // Reset and input synchronisers
  // ********************
  logic rst_n;
  logic supply_ok;
  logic plat_rst_n;
  logic hard_rst;
  logic strap;
  logic slow_in;
  logic ref_in;
  // Release the standby reset through two flops; assertion stays asynchronous.
  pds_sync u_sync_rst (.i_clk(i_sys_clk), .i_rst_n(i_arst_n), .i_d(1'b1), .o_q(rst_n));
  pds_sync u_sync_ok (.i_clk(i_sys_clk), .i_rst_n(rst_n), .i_d(i_main_supply_ok), .o_q(supply_ok));
  pds_sync u_sync_prst (.i_clk(i_sys_clk), .i_rst_n(rst_n), .i_d(i_platform_reset_in_n),
    .o_q(plat_rst_n));
  pds_sync u_sync_hrst (.i_clk(i_sys_clk), .i_rst_n(rst_n), .i_d(i_hard_reset), .o_q(hard_rst));
  pds_sync u_sync_strap (.i_clk(i_sys_clk), .i_rst_n(rst_n), .i_d(i_config_base_strap),
    .o_q(strap));
  pds_sync u_sync_slow (.i_clk(i_sys_clk), .i_rst_n(rst_n), .i_d(i_slow_clock_in), .o_q(slow_in));
  pds_sync u_sync_ref (.i_clk(i_sys_clk), .i_rst_n(rst_n), .i_d(i_ref_clock_in), .o_q(ref_in));

  // ********************
  // Power sequencing
  // ********************
  pds_pkg::pds_state_t state;
  pds_pkg::pds_state_t next_state;
  logic main_reset;
  // Main domain sits in reset while supply is bad or a reset is asserted.
  always_comb
  begin
    main_reset = 1'b1;
    case (state)
      pds_pkg::PDS_OFF:
        next_state = supply_ok ? pds_pkg::PDS_HOLD : pds_pkg::PDS_OFF;
      pds_pkg::PDS_HOLD:
      begin
        if (!supply_ok)
          next_state = pds_pkg::PDS_OFF;
        else if (plat_rst_n && !hard_rst)
          next_state = pds_pkg::PDS_RUN;
        else
          next_state = pds_pkg::PDS_HOLD;
      end
      pds_pkg::PDS_RUN:
      begin
        main_reset = 1'b0;
        if (!supply_ok)
          next_state = pds_pkg::PDS_OFF;
        else if (!plat_rst_n || hard_rst)
          next_state = pds_pkg::PDS_HOLD;
        else
          next_state = pds_pkg::PDS_RUN;
      end
      default:
        next_state = pds_pkg::PDS_OFF;
    endcase
  end
  always_ff @(posedge i_sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      state <= pds_pkg::PDS_OFF;
    else
      state <= next_state;
  end

  // ********************
  // Registers
  // ********************
  // Presence lives on standby; pin control is main-domain except the pin mode bits.
  logic absent;
  logic activate;
  logic kbd_func;
  logic gate_func;
  logic ir_to_en;
  logic fan_inv;
  logic [11:0] base;
  logic strap_taken;
  logic next_absent;
  logic next_activate;
  logic next_kbd_func;
  logic next_gate_func;
  logic next_ir_to_en;
  logic next_fan_inv;
  logic [11:0] next_base;
  logic next_strap_taken;
  logic [7:0] next_rdata;
  logic host_ok;
  always_comb
  begin
    host_ok = (state == pds_pkg::PDS_RUN);
    next_absent = absent;
    next_activate = activate;
    next_kbd_func = kbd_func;
    next_gate_func = gate_func;
    next_ir_to_en = ir_to_en;
    next_fan_inv = fan_inv;
    next_base = base;
    next_strap_taken = strap_taken;
    next_rdata = 8'h00;
    // The strap is taken once the main domain leaves reset.
    if (main_reset)
      next_strap_taken = 1'b0;
    else if (!strap_taken)
    begin
      next_strap_taken = 1'b1;
      next_base = strap ? pds_pkg::CONFIG_BASE_HIGH : pds_pkg::CONFIG_BASE_LOW;
    end
    if (host_ok && i_wr)
    begin
      case (i_addr)
        pds_pkg::SLOW_CLOCK_PRESENCE_ADDR:
          next_absent = i_wdata[pds_pkg::SLOW_CLOCK_ABSENT_BIT];
        pds_pkg::PIN_CONTROL_ADDR:
        begin
          next_activate = i_wdata[pds_pkg::ACTIVATE_BIT];
          next_kbd_func = i_wdata[pds_pkg::KBD_FUNC_BIT];
          next_gate_func = i_wdata[pds_pkg::GATE_FUNC_BIT];
          next_ir_to_en = i_wdata[pds_pkg::IR_TIMEOUT_EN_BIT];
          next_fan_inv = i_wdata[pds_pkg::FAN_INVERT_BIT];
        end
        default:
          next_absent = absent;
      endcase
    end
    if (host_ok && i_rd)
    begin
      case (i_addr)
        pds_pkg::SLOW_CLOCK_PRESENCE_ADDR:
          next_rdata = {7'h00, absent};
        pds_pkg::PIN_CONTROL_ADDR:
          next_rdata = {3'h0, fan_inv, ir_to_en, gate_func, kbd_func, activate};
        pds_pkg::POWER_STATUS_ADDR:
          next_rdata = {4'h0, strap, state};
        default:
          next_rdata = 8'h00;
      endcase
    end
    // Main-domain settings drop back when the supply goes or a reset hits.
    if (main_reset)
    begin
      next_activate = 1'b0;
      next_ir_to_en = 1'b0;
      next_fan_inv = 1'b0;
    end
  end
  // Standby reset clears everything but the base, which loads CONFIG_BASE_LOW, including the pin mode bits.
  always_ff @(posedge i_sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      absent <= pds_pkg::SLOW_CLOCK_PRESENCE_RESET;
      activate <= 1'b0;
      kbd_func <= 1'b0;
      gate_func <= 1'b0;
      ir_to_en <= 1'b0;
      fan_inv <= 1'b0;
      base <= pds_pkg::CONFIG_BASE_LOW;
      strap_taken <= 1'b0;
      o_rdata <= 8'h00;
    end
    else
    begin
      absent <= next_absent;
      activate <= next_activate;
      kbd_func <= next_kbd_func;
      gate_func <= next_gate_func;
      ir_to_en <= next_ir_to_en;
      fan_inv <= next_fan_inv;
      base <= next_base;
      strap_taken <= next_strap_taken;
      o_rdata <= next_rdata;
    end
  end

  // ********************
  // Slow clock
  // ********************
  logic slow_sel;
  // The derived source is only valid while the main supply runs the reference.
  pds_slow_clock u_slow (
    .i_clk(i_sys_clk),
    .i_rst_n(rst_n),
    .i_ref_level(ref_in),
    .i_ext_level(slow_in),
    .i_use_derived(absent),
    .o_slow(slow_sel)
  );

  // ********************
  // Pin outputs
  // ********************
  logic next_ir;
  logic [1:0] next_fan;
  // Standby-powered pins stay under logic control whatever the supply does.
  always_comb
  begin
    next_ir = (activate && !main_reset) ? i_uart2_txd : 1'b0;
    if (main_reset && supply_ok)
      next_fan = 2'b00;
    else if (!supply_ok)
      next_fan = i_fan_gpio;
    else
      next_fan = fan_inv ? ~i_fan_pwm : i_fan_pwm;
  end
  always_ff @(posedge i_sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      o_infrared_transmit_pin_a <= 1'b0;
      o_infrared_transmit_pin_b <= 1'b0;
      o_fan_drive_out_1 <= 1'b0;
      o_fan_drive_out_2 <= 1'b0;
      o_indicator_out_1 <= 1'b0;
      o_indicator_out_2 <= 1'b0;
      o_keyboard_reset_out <= 1'b1;
      o_keyboard_reset_oe <= 1'b0;
      o_gate_a20_out <= 1'b1;
      o_gate_a20_oe <= 1'b0;
      o_wake_event_out_n <= 1'b1;
      o_config_base <= pds_pkg::CONFIG_BASE_LOW;
      o_ir_timeout_en <= 1'b0;
      o_main_domain_rst_n <= 1'b0;
      o_slow_clock <= 1'b0;
    end
    else
    begin
      o_infrared_transmit_pin_a <= next_ir;
      o_infrared_transmit_pin_b <= next_ir;
      o_fan_drive_out_1 <= next_fan[0];
      o_fan_drive_out_2 <= next_fan[1];
      o_indicator_out_1 <= i_led[0];
      o_indicator_out_2 <= i_led[1];
      o_keyboard_reset_out <= i_kbd_reset_func;
      o_keyboard_reset_oe <= kbd_func && !main_reset;
      o_gate_a20_out <= i_gate_a20_func;
      o_gate_a20_oe <= gate_func && !main_reset;
      o_wake_event_out_n <= !i_wake_event;
      o_config_base <= base;
      o_ir_timeout_en <= ir_to_en && supply_ok;
      o_main_domain_rst_n <= !main_reset;
      o_slow_clock <= slow_sel;
    end
  end

  // ********************
  // Assertions
  // ********************
  a_host_gated: assert property (@(posedge i_sys_clk) disable iff (!rst_n)
    !supply_ok |=> ##1 o_rdata == 8'h00) else $error("read answered without supply");
  a_ir_timeout_off: assert property (@(posedge i_sys_clk) disable iff (!rst_n)
    !supply_ok |=> !o_ir_timeout_en) else $error("timeout on without supply");
  a_ir_low_idle: assert property (@(posedge i_sys_clk) disable iff (!rst_n)
    !activate |=> !o_infrared_transmit_pin_a && !o_infrared_transmit_pin_b)
    else $error("infrared not low");
  a_fan_reset_low: assert property (@(posedge i_sys_clk) disable iff (!rst_n)
    (main_reset && supply_ok) |=> !o_fan_drive_out_1 && !o_fan_drive_out_2)
    else $error("fan not low in reset");
  a_fan_gpio_off: assert property (@(posedge i_sys_clk) disable iff (!rst_n)
    !supply_ok |=> o_fan_drive_out_1 == $past(i_fan_gpio[0]))
    else $error("fan not plain output");
  a_main_held: assert property (@(posedge i_sys_clk) disable iff (!rst_n)
    !supply_ok |-> ##2 !o_main_domain_rst_n) else $error("main domain not held");
  a_kbd_input: assert property (@(posedge i_sys_clk) disable iff (!rst_n)
    !kbd_func |=> !o_keyboard_reset_oe) else $error("keyboard pin driven");
  a_base_select: assert property (@(posedge i_sys_clk) disable iff (!rst_n)
    (!main_reset && !strap_taken) |=> base == (($past(strap)) ? pds_pkg::CONFIG_BASE_HIGH
    : pds_pkg::CONFIG_BASE_LOW)) else $error("wrong config base");
endmodule
`default_nettype wire

// ==== pds_host_model.sv ====
// Host chipset model: drives the register port and the platform reset.
// Assumes the block samples every request on the rising clock edge.
`timescale 1ns/1ps
`default_nettype none
module pds_host_model
(
  // Clock.
  input wire logic i_clk,
  // Register port.
  output logic [7:0] o_addr,
  output logic [7:0] o_wdata,
  output logic o_wr,
  output logic o_rd,
  input wire logic [7:0] i_rdata,
  // Platform reset.
  output logic o_platform_reset_n
);
  // ****************
  // Bus cycles
  // ****************
  // Idle levels; address and data carry junk when no cycle runs.
  initial
  begin
    o_addr = 8'h5a;
    o_wdata = 8'ha5;
    o_wr = 1'h0;
    o_rd = 1'h0;
    o_platform_reset_n = 1'h1;
  end
  // One write cycle; afterwards the lines are scrambled, not held.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clk);
    o_addr <= a;
    o_wdata <= d;
    o_wr <= 1'h1;
    @(posedge i_clk);
    o_wr <= 1'h0;
    o_addr <= ~a;
    o_wdata <= ~d;
  endtask
  // One read cycle; data stands only in the cycle after the strobe.
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge i_clk);
    o_addr <= a;
    o_rd <= 1'h1;
    @(posedge i_clk);
    o_rd <= 1'h0;
    o_addr <= ~a;
    #1;
    d = i_rdata;
  endtask
  // Platform reset moves only on a clock edge and is held by the caller.
  task automatic plat(input logic v);
    @(posedge i_clk);
    o_platform_reset_n <= v;
  endtask
endmodule
`default_nettype wire

// ==== test_power_domain_reset_defaults.sv ====
// Self-checking bench for the power-domain and reset-default block.
// Assumes the host model drives the register port and platform reset.
`timescale 1ns/1ps
`default_nettype none
module test_power_domain_reset_defaults;
  logic clk = 1'b0;
  logic ref_clk = 1'b0;
  logic arst_n, sup, hrst, strap, sin, txd, kf, gf, wake;
  logic [1:0] pwm, fgp, led;
  logic [7:0] addr, wdata, rdata, d;
  logic wr, rd, prst_n, iri, irb, f1, f2, ind1, ind2, ko, go, koe, goe, wn, toe, mrst_n, slow;
  logic [11:0] base;
  logic [9:0] rows [4];
  int bad_count, n_tests, k, i;
  // ****************
  // Clocks and parts
  // ****************
  // The reference runs at one seventh of the system clock, its edges landing on system clock edges.
  always #5 clk = ~clk;
  always #35 ref_clk = ~ref_clk;
  pds_host_model h (.i_clk(clk), .o_addr(addr), .o_wdata(wdata), .o_wr(wr),
    .o_rd(rd), .i_rdata(rdata), .o_platform_reset_n(prst_n));
  pds_power_domain uut (.i_sys_clk(clk), .i_arst_n(arst_n), .i_main_supply_ok(sup),
    .i_platform_reset_in_n(prst_n), .i_hard_reset(hrst), .i_config_base_strap(strap),
    .i_slow_clock_in(sin), .i_ref_clock_in(ref_clk), .i_addr(addr), .i_wdata(wdata),
    .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_uart2_txd(txd), .i_fan_pwm(pwm),
    .i_fan_gpio(fgp), .i_led(led), .i_kbd_reset_func(kf), .i_gate_a20_func(gf),
    .i_wake_event(wake), .o_infrared_transmit_pin_a(iri),
    .o_infrared_transmit_pin_b(irb), .o_fan_drive_out_1(f1), .o_fan_drive_out_2(f2),
    .o_indicator_out_1(ind1), .o_indicator_out_2(ind2), .o_keyboard_reset_out(ko),
    .o_keyboard_reset_oe(koe), .o_gate_a20_out(go), .o_gate_a20_oe(goe),
    .o_wake_event_out_n(wn), .o_config_base(base), .o_ir_timeout_en(toe),
    .o_main_domain_rst_n(mrst_n), .o_slow_clock(slow));
  // ****************
  // Helpers
  // ****************
  // Compare and count; a mismatch is printed at once.
  task automatic check(input logic [11:0] s, input logic [11:0] e);
    n_tests++;
    if (s !== e)
    begin
      $display("Error at %0t: seen %h expected %h", $time, s, e);
      bad_count++;
    end
  endtask
  // Print the counts and the verdict, then stop.
  task automatic give_verdict();
    $display("checks %0d errors %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // Let edges pass, then step off the edge so outputs have settled.
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // Bounded wait for the main domain to leave reset.
  task automatic wait_run();
    for (k = 0; k < 50 && mrst_n !== 1'h1; k++)
      step(1);
    if (mrst_n !== 1'h1)
    begin
      bad_count++;
      give_verdict();
    end
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
    h.rd(a, d);
    check(12'(d), 12'(e));
  endtask
  // ****************
  // Main sequence
  // ****************
  // Pin rows: {led, wake, pwm} beside {indicators, wake_n, fans}.
  initial
  begin
    {arst_n, sup, hrst, strap, sin, txd, wake} = 7'h0;
    kf = 1'h1;
    gf = 1'h1;
    {pwm, fgp, led} = 6'h0;
    rows = '{10'h004, 10'h1ca, 10'h235, 10'h3fb};
    repeat (20) @(posedge clk);
    arst_n <= 1'h1;
    step(4);
    check(12'({iri, irb, f2, f1, koe, goe, toe, mrst_n}), 12'h0);
    check(12'(wn), 12'h1);
    check(base, 12'h02e);
    h.wr(8'hf1, 8'h09);
    @(posedge clk);
    sup <= 1'h1;
    pwm <= 2'h3;
    txd <= 1'h1;
    step(3);
    check(12'({f2, f1}), 12'h0);
    wait_run();
    rdchk(8'hf1, 8'h00);
    rdchk(8'hf0, 8'h00);
    rdchk(8'hf2, 8'h04);
    check(12'({iri, irb, toe}), 12'h0);
    h.wr(8'hf1, 8'h0f);
    step(3);
    check(12'({iri, irb, toe, koe, goe}), 12'h1f);
    @(posedge clk);
    txd <= 1'h0;
    kf <= 1'h0;
    step(3);
    check(12'({iri, irb, ko, go}), 12'h1);
    // Ordinary pin traffic while the main domain runs.
    for (i = 0; i < 4; i++)
    begin
      @(posedge clk);
      {led, wake, pwm} <= rows[i][9:5];
      step(3);
      check(12'({ind2, ind1, wn, f2, f1}), 12'(rows[i][4:0]));
    end
    // A hard reset forces fans low and drops the activate bit.
    @(posedge clk);
    txd <= 1'h1;
    hrst <= 1'h1;
    step(6);
    check(12'({f2, f1, iri, irb, mrst_n}), 12'h0);
    @(posedge clk);
    hrst <= 1'h0;
    wait_run();
    rdchk(8'hf1, 8'h06);
    check(12'({iri, irb}), 12'h0);
    // Slow clock first from the pin, then derived from the reference.
    @(posedge clk);
    sin <= 1'h1;
    step(5);
    check(12'(slow), 12'h1);
    @(posedge clk);
    sin <= 1'h0;
    step(5);
    check(12'(slow), 12'h0);
    h.wr(8'hf0, 8'h01);
    rdchk(8'hf0, 8'h01);
    for (k = 0; k < 4000 && slow !== 1'h1; k++)
      step(1);
    check(12'(slow), 12'h1);
    if (slow !== 1'h1)
      give_verdict();
    // Fan invert set as well: the running fans show the inverted PWM.
    h.wr(8'hf1, 8'h1f);
    step(3);
    check(12'({iri, irb, toe, f2, f1}), 12'h1c);
    // Main supply lost: standby pins live, host cycles ignored.
    @(posedge clk);
    sup <= 1'h0;
    fgp <= 2'h2;
    led <= 2'h1;
    wake <= 1'h1;
    step(6);
    check(12'({iri, irb, toe, mrst_n}), 12'h0);
    check(12'({f2, f1, ind2, ind1, wn}), 12'h12);
    rdchk(8'hf0, 8'h00);
    // Supply back with the strap high; standby bits were kept.
    @(posedge clk);
    sup <= 1'h1;
    strap <= 1'h1;
    wait_run();
    step(1);
    check(base, 12'h04e);
    rdchk(8'hf0, 8'h01);
    rdchk(8'hf2, 8'h0c);
    h.plat(1'h0);
    step(6);
    check(12'(mrst_n), 12'h0);
    h.plat(1'h1);
    wait_run();
    // A standby reset clears the standby registers.
    @(posedge clk);
    arst_n <= 1'h0;
    step(2);
    @(posedge clk);
    arst_n <= 1'h1;
    wait_run();
    rdchk(8'hf0, 8'h00);
    rdchk(8'hf1, 8'h00);
    give_verdict();
  end
endmodule
`default_nettype wire
